// ===== rtl/tmic_regs.sv
`timescale 1ns/1ps
`include "tmic_consts.svh"

// What this block does
// - Power-down bit 5 set disables all outputs and unterminates all inputs.
// - Low-power request is power-down bit OR power-down pin.
// - Serial management bus keeps working in low-power state.
// - Input-control bit 2 tri-states clock inputs, removing termination.
// - Input-control bit 3 tri-states data inputs, removing termination.
// - Bit 4 picks toggle detection or common-mode level detection.
// - Bit 5 enables hysteresis on clock inputs only.
// - Bit 6 picks 10mV or 20mV clock hysteresis.
// - Termination calibrates by itself after power-on.
// - Termination bit 2 selects 50 or 100 ohm data termination.
// - Termination bit 6 selects 50 or 100 ohm clock termination.
// - Activity status bit 2 reads 1 when a clock is detected.
module tmic_regs #(
  parameter logic [6:0]  DEV_ADDR   = `TMIC_DEV_ADDR,
  parameter logic [15:0] CAL_CYCLES =
    16'(`TMIC_CAL_TIME_US * `TMIC_CLK_MHZ),
  parameter logic [7:0]  ACT_WINDOW = `TMIC_ACT_WINDOW
) (
  input  wire logic i_clk,            // 20 MHz system clock
  input  wire logic i_reset_n,        // Async reset, active low
  input  wire logic i_scl,            // Serial bus clock pin
  input  wire logic i_sda,            // Serial bus data pin, in
  output logic      o_sda_o,          // Serial bus data, out level
  output logic      o_sda_oe,         // Serial bus data, pull low
  input  wire logic i_pd_pin,         // External power-down pin
  input  wire logic i_clk_toggle,     // Clock pair toggle comparator
  input  wire logic i_clk_cm_high,    // Clock pair common-mode high
  output logic      o_low_power_state,// Chip in lowest power
  output logic      o_outputs_off,    // All TMDS outputs off
  output logic      o_clk_term_en,    // Clock pair terminated
  output logic      o_data_term_en,   // Data pairs terminated
  output logic      o_clk_term_100,   // Clock termination 100 ohm
  output logic      o_data_term_100,  // Data termination 100 ohm
  output logic      o_hyst_en,        // Clock input hysteresis on
  output logic      o_hyst_20mv,      // Hysteresis 20mV, else 10mV
  output logic      o_act_mode_cm,    // Common-mode activity method
  output logic      o_term_cal        // Termination calibration run
);
  import tmic_pkg::*;

  tmic_regs_state_t s_reg;
  tmic_regs_state_t s_next;
  logic             act_enable;
  logic             clk_active;

  function automatic logic [7:0] read_byte(
    input logic [7:0]       ofs,
    input tmic_regs_state_t s,
    input logic             active
  );
    logic [7:0] v;
    v = `TMIC_ZERO_BYTE;
    case (ofs)
      `TMIC_OFS_ACTIVITY: v[`TMIC_ACT_STATUS_BIT] = active;
      `TMIC_OFS_POWER:    v[`TMIC_PWR_DOWN_BIT]   = s.pd_bit;
      `TMIC_OFS_INPUT:    v = s.in_ctrl;
      `TMIC_OFS_TERM:     v = s.term_sel;
      default:            v = `TMIC_ZERO_BYTE;
    endcase
    return v;
  endfunction

  // Load a read byte; its first bit goes out with the load
  function automatic tmic_regs_state_t load_tx(
    input tmic_regs_state_t s,
    input tmic_regs_state_t n,
    input logic [7:0]       rd
  );
    tmic_regs_state_t r;
    r        = n;
    r.state  = TMIC_TX;
    r.sda_oe = !rd[7];
    r.shreg  = {rd[6:0], 1'b1};
    r.bitcnt = `TMIC_FIRST_BIT;
    r.ptr    = s.ptr + 8'h01;
    return r;
  endfunction

  // Analog steering from register contents
  function automatic tmic_analog_ctl_t analog_ctl(
    input logic [7:0] in_ctrl,
    input logic [7:0] term_sel,
    input logic       pd,
    input logic       cal
  );
    tmic_analog_ctl_t a;
    a                 = '0;
    a.low_power_state = pd;
    a.outputs_off     = pd;
    // Low power unterminates both pairs
    a.clk_term_en     = !pd && !in_ctrl[`TMIC_IN_CLK_TRI];
    a.data_term_en    = !pd && !in_ctrl[`TMIC_IN_DATA_TRI];
    // 100 ohm only while the pair is terminated
    a.clk_term_100    = a.clk_term_en &&
                        term_sel[`TMIC_TERM_CLK_100];
    a.data_term_100   = a.data_term_en &&
                        term_sel[`TMIC_TERM_DATA_100];
    a.hyst_en         = in_ctrl[`TMIC_IN_HYST_EN];
    a.hyst_20mv       = in_ctrl[`TMIC_IN_HYST_MAG];
    a.act_mode_cm     = in_ctrl[`TMIC_IN_ACT_MODE];
    a.term_cal        = cal || in_ctrl[`TMIC_IN_RECAL];
    return a;
  endfunction

  assign act_enable = !s_reg.ana.low_power_state &&
                      !s_reg.in_ctrl[`TMIC_IN_CLK_TRI];

  tmic_activity_detect #(
    .ACT_WINDOW (ACT_WINDOW)
  ) u_act (
    .i_clk        (i_clk),
    .i_reset_n    (i_reset_n),
    .i_toggle_pin (i_clk_toggle),
    .i_cm_high_pin(i_clk_cm_high),
    .i_mode_cm    (s_reg.in_ctrl[`TMIC_IN_ACT_MODE]),
    .i_enable     (act_enable),
    .o_active     (clk_active)
  );

  always_comb begin
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       pd;
    logic [7:0] rd;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c  = 1'b0;
    stop_c   = 1'b0;
    pd       = 1'b0;
    rd       = `TMIC_ZERO_BYTE;
    s_next   = s_reg;

    // Pin synchronisers; second stages and the delayed scl_d/sda_d copies feed logic
    s_next.pins.scl1  = i_scl;
    s_next.pins.scl2  = s_reg.pins.scl1;
    s_next.pins.scl_d = s_reg.pins.scl2;
    s_next.pins.sda1  = i_sda;
    s_next.pins.sda2  = s_reg.pins.sda1;
    s_next.pins.sda_d = s_reg.pins.sda2;
    s_next.pins.pd1   = i_pd_pin;
    s_next.pins.pd2   = s_reg.pins.pd1;

    scl_rise = s_reg.pins.scl2 && !s_reg.pins.scl_d;
    scl_fall = !s_reg.pins.scl2 && s_reg.pins.scl_d;
    start_c  = s_reg.pins.scl2 && s_reg.pins.scl_d &&
               s_reg.pins.sda_d && !s_reg.pins.sda2;
    stop_c   = s_reg.pins.scl2 && s_reg.pins.scl_d &&
               !s_reg.pins.sda_d && s_reg.pins.sda2;
    rd       = read_byte(s_reg.ptr, s_reg, clk_active);

    // Bus engine runs regardless of power state
    if (start_c) begin
      s_next.state  = TMIC_RX;
      s_next.phase  = TMIC_PH_ADDR;
      s_next.bitcnt = '0;
      s_next.sda_oe = 1'b0;
    end else if (stop_c) begin
      s_next.state  = TMIC_IDLE;
      s_next.sda_oe = 1'b0;
    end else begin
      case (s_reg.state)
        TMIC_IDLE: begin
          s_next.sda_oe = 1'b0;
        end
        TMIC_RX: begin
          if (scl_rise) begin
            s_next.shreg  = {s_reg.shreg[6:0], s_reg.pins.sda2};
            s_next.bitcnt = s_reg.bitcnt + 4'h1;
          end else if (scl_fall &&
                       s_reg.bitcnt == `TMIC_BITS_PER_BYTE) begin
            s_next.bitcnt = '0;
            s_next.state  = TMIC_ACK;
            s_next.sda_oe = 1'b1;
            case (s_reg.phase)
              TMIC_PH_ADDR: begin
                if (s_reg.shreg[7:1] == DEV_ADDR) begin
                  s_next.rw    = s_reg.shreg[0];
                  s_next.phase = TMIC_PH_PTR;
                end else begin
                  s_next.state  = TMIC_IDLE;
                  s_next.sda_oe = 1'b0;
                end
              end
              TMIC_PH_PTR: begin
                s_next.ptr   = s_reg.shreg;
                s_next.phase = TMIC_PH_DATA;
              end
              TMIC_PH_DATA: begin
                case (s_reg.ptr)
                  `TMIC_OFS_POWER:
                    s_next.pd_bit = s_reg.shreg[`TMIC_PWR_DOWN_BIT];
                  `TMIC_OFS_INPUT:
                    s_next.in_ctrl = s_reg.shreg;
                  `TMIC_OFS_TERM:
                    s_next.term_sel = s_reg.shreg & `TMIC_TERM_MASK;
                  default: begin
                  end
                endcase
                s_next.ptr = s_reg.ptr + 8'h01;
              end
              default: begin
                s_next.state  = TMIC_IDLE;
                s_next.sda_oe = 1'b0;
              end
            endcase
          end
        end
        // Ack pull stands until the next bus clock fall
        TMIC_ACK: begin
          if (scl_fall) begin
            if (s_reg.rw) begin
              s_next = load_tx(s_reg, s_next, rd);
            end else begin
              s_next.state  = TMIC_RX;
              s_next.sda_oe = 1'b0;
              s_next.bitcnt = '0;
            end
          end
        end
        TMIC_TX: begin
          if (scl_fall) begin
            if (s_reg.bitcnt == `TMIC_BITS_PER_BYTE) begin
              s_next.state  = TMIC_MACK;
              s_next.sda_oe = 1'b0;
              s_next.bitcnt = '0;
            end else begin
              s_next.sda_oe = !s_reg.shreg[7];
              s_next.shreg  = {s_reg.shreg[6:0], 1'b1};
              s_next.bitcnt = s_reg.bitcnt + 4'h1;
            end
          end
        end
        TMIC_MACK: begin
          if (scl_rise && s_reg.pins.sda2) begin
            s_next.state = TMIC_IDLE;
          end else if (scl_fall) begin
            s_next = load_tx(s_reg, s_next, rd);
          end
        end
        default: begin
          s_next.state  = TMIC_IDLE;
          s_next.sda_oe = 1'b0;
        end
      endcase
    end
    s_next.sda_o = 1'b0;

    // Power-on termination calibration
    if (s_reg.cal_busy) begin
      s_next.cal_cnt = s_reg.cal_cnt + 16'h0001;
      if (s_reg.cal_cnt == CAL_CYCLES - 16'h0001) begin
        s_next.cal_busy = 1'b0;
      end
    end

    // Analog controls follow the next register values
    pd = s_next.pd_bit || s_reg.pins.pd2;
    s_next.ana = analog_ctl(s_next.in_ctrl, s_next.term_sel, pd,
                            s_next.cal_busy);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_reg          <= '0;
      s_reg.state    <= TMIC_IDLE;
      s_reg.phase    <= TMIC_PH_ADDR;
      s_reg.in_ctrl  <= `TMIC_INPUT_RESET;
      s_reg.term_sel <= `TMIC_TERM_RESET;
      s_reg.cal_busy <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs taken straight from the state register
  assign o_sda_o           = s_reg.sda_o;
  assign o_sda_oe          = s_reg.sda_oe;
  assign o_low_power_state = s_reg.ana.low_power_state;
  assign o_outputs_off     = s_reg.ana.outputs_off;
  assign o_clk_term_en     = s_reg.ana.clk_term_en;
  assign o_data_term_en    = s_reg.ana.data_term_en;
  assign o_clk_term_100    = s_reg.ana.clk_term_100;
  assign o_data_term_100   = s_reg.ana.data_term_100;
  assign o_hyst_en         = s_reg.ana.hyst_en;
  assign o_hyst_20mv       = s_reg.ana.hyst_20mv;
  assign o_act_mode_cm     = s_reg.ana.act_mode_cm;
  assign o_term_cal        = s_reg.ana.term_cal;

endmodule

// ===== rtl/tmic_consts.svh
`ifndef TMIC_CONSTS_SVH
`define TMIC_CONSTS_SVH

// Register offsets on the serial management bus
`define TMIC_OFS_ACTIVITY   8'h01
`define TMIC_OFS_POWER      8'h02
`define TMIC_OFS_INPUT      8'h03
`define TMIC_OFS_TERM       8'h04

// Field positions
`define TMIC_ACT_STATUS_BIT 2
`define TMIC_PWR_DOWN_BIT   5
`define TMIC_IN_CLK_TRI     2
`define TMIC_IN_DATA_TRI    3
`define TMIC_IN_ACT_MODE    4
`define TMIC_IN_HYST_EN     5
`define TMIC_IN_HYST_MAG    6
`define TMIC_IN_RECAL       7
`define TMIC_TERM_DATA_100  2
`define TMIC_TERM_CLK_100   6

// Reset values and masks
`define TMIC_INPUT_RESET    8'h12
`define TMIC_TERM_RESET     8'h00
`define TMIC_TERM_MASK      8'h44
`define TMIC_ZERO_BYTE      8'h00

// Serial bus framing
`define TMIC_BITS_PER_BYTE  4'h8
`define TMIC_FIRST_BIT      4'h1
`define TMIC_DEV_ADDR       7'h2A

// Timing
`define TMIC_CLK_MHZ        20
`define TMIC_CAL_TIME_US    1000
`define TMIC_ACT_WINDOW     8'h40

`endif

// ===== rtl/tmic_pkg.sv
package tmic_pkg;

  typedef enum logic [2:0] {
    TMIC_IDLE,
    TMIC_RX,
    TMIC_ACK,
    TMIC_TX,
    TMIC_MACK
  } tmic_bus_state_t;

  typedef enum logic [1:0] {
    TMIC_PH_ADDR,
    TMIC_PH_PTR,
    TMIC_PH_DATA
  } tmic_phase_t;

  typedef struct packed {
    logic scl1;
    logic scl2;
    logic scl_d;
    logic sda1;
    logic sda2;
    logic sda_d;
    logic pd1;
    logic pd2;
  } tmic_pin_sync_t;

  typedef struct packed {
    logic clk_term_en;
    logic data_term_en;
    logic clk_term_100;
    logic data_term_100;
    logic hyst_en;
    logic hyst_20mv;
    logic act_mode_cm;
    logic low_power_state;
    logic outputs_off;
    logic term_cal;
  } tmic_analog_ctl_t;

  typedef struct packed {
    tmic_bus_state_t  state;
    tmic_phase_t      phase;
    logic             rw;
    logic [7:0]       shreg;
    logic [3:0]       bitcnt;
    logic [7:0]       ptr;
    logic             sda_oe;
    logic             sda_o;
    logic             pd_bit;
    logic [7:0]       in_ctrl;
    logic [7:0]       term_sel;
    tmic_pin_sync_t   pins;
    logic [15:0]      cal_cnt;
    logic             cal_busy;
    tmic_analog_ctl_t ana;
  } tmic_regs_state_t;

  typedef struct packed {
    logic       tg1;
    logic       tg2;
    logic       tg3;
    logic       cm1;
    logic       cm2;
    logic [7:0] idle_cnt;
    logic       active;
  } tmic_act_state_t;

endpackage

// ===== rtl/tmic_activity_detect.sv
`timescale 1ns/1ps
`include "tmic_consts.svh"

module tmic_activity_detect #(
  parameter logic [7:0] ACT_WINDOW = `TMIC_ACT_WINDOW
) (
  input  wire logic i_clk,          // System clock
  input  wire logic i_reset_n,      // Async reset, active low
  input  wire logic i_toggle_pin,   // Clock pair comparator output
  input  wire logic i_cm_high_pin,  // Common-mode above threshold
  input  wire logic i_mode_cm,      // 1: common-mode method
  input  wire logic i_enable,       // Clock pair powered and terminated
  output logic      o_active        // Clock seen on the pair
);
  import tmic_pkg::*;

  tmic_act_state_t s_reg;
  tmic_act_state_t s_next;

  always_comb begin
    s_next     = s_reg;
    s_next.tg1 = i_toggle_pin;
    s_next.tg2 = s_reg.tg1;
    s_next.tg3 = s_reg.tg2;
    s_next.cm1 = i_cm_high_pin;
    s_next.cm2 = s_reg.cm1;
    // Edge restarts the quiet-time window
    if (s_reg.tg2 != s_reg.tg3) begin
      s_next.idle_cnt = '0;
    end else if (s_reg.idle_cnt != ACT_WINDOW) begin
      s_next.idle_cnt = s_reg.idle_cnt + 8'h01;
    end
    if (!i_enable) begin
      s_next.active = 1'b0;
    end else if (i_mode_cm) begin
      s_next.active = s_reg.cm2;
    end else begin
      s_next.active = (s_reg.idle_cnt != ACT_WINDOW);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_active = s_reg.active;

endmodule

// ===== sim/tmic_host_model.sv
`timescale 1ns/1ps

module tmic_host_model #(
  parameter logic [6:0] DEV_ADDR    = 7'h2A,
  parameter int         HALF        = 10,
  parameter int         HOLD_CYCLES = 20000
) (
  input  wire logic i_clk,     // System clock
  input  wire logic i_sda,     // Resolved data line
  output logic      o_scl,     // Bus clock, idles high
  output logic      o_sda_low  // Pulls data line low
);
  logic [6:0] dev = DEV_ADDR;
  logic       acked;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    acked = 1'b0;
  end
  task automatic wt();
    repeat (HALF) @(posedge i_clk);
  endtask
  task automatic bit_io(input logic b, output logic s);
    o_sda_low <= !b;
    wt();
    o_scl <= 1'b1;
    wt();
    s = i_sda;
    o_scl <= 1'b0;
    wt();
  endtask
  task automatic start();
    o_sda_low <= 1'b1;
    wt();
    o_scl <= 1'b0;
    wt();
  endtask
  task automatic restart();
    o_sda_low <= 1'b0;
    wt();
    o_scl <= 1'b1;
    wt();
    start();
  endtask
  task automatic stop();
    o_sda_low <= 1'b1;
    wt();
    o_scl <= 1'b1;
    wt();
    o_sda_low <= 1'b0;
    wt();
  endtask
  task automatic byte_out(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    acked = acked & !s;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    acked = 1'b1;
    start();
    byte_out({dev, 1'b0});
    byte_out(ofs);
    byte_out(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    logic s;
    acked = 1'b1;
    start();
    byte_out({dev, 1'b0});
    byte_out(ofs);
    restart();
    byte_out({dev, 1'b1});
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, s);
      d = {d[6:0], s};
    end
    bit_io(1'b1, s);
    stop();
  endtask
  // Recalibrate bit held high for the full hold time
  task automatic hold_cal();
    repeat (HOLD_CYCLES) @(posedge i_clk);
  endtask
endmodule

// ===== sim/tmic_regs_assertions.sv
`timescale 1ns/1ps

module tmic_regs_assertions #(
  parameter logic [15:0] CAL_CYCLES = 16'h4E20
) (
  input  wire logic i_clk,             // Clock
  input  wire logic i_reset_n,         // Reset
  input  wire logic i_scl,             // Bus clock
  input  wire logic i_pd_pin,          // Power-down pin
  input  wire logic o_sda_oe,          // Data pull low
  input  wire logic o_low_power_state, // Low power
  input  wire logic o_outputs_off,     // Outputs off
  input  wire logic o_clk_term_en,     // Clock terminated
  input  wire logic o_data_term_en,    // Data terminated
  input  wire logic o_clk_term_100,    // Clock 100 ohm
  input  wire logic o_data_term_100,   // Data 100 ohm
  input  wire logic o_hyst_en,         // Hysteresis on
  input  wire logic o_hyst_20mv,       // Hysteresis 20mV
  input  wire logic o_act_mode_cm,     // Common-mode method
  input  wire logic o_term_cal         // Calibration running
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic [15:0] up_reg;
  logic [15:0] up_next;
  always_comb up_next = (up_reg == 16'hFFFF) ? up_reg : up_reg + 16'h0001;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) up_reg <= 16'h0000;
    else up_reg <= up_next;
  end
  a_lp_term_off: assert property (o_low_power_state |->
    !o_clk_term_en && !o_data_term_en) else $error("term on in low power");
  a_outputs_off_eq: assert property (o_outputs_off == o_low_power_state)
    else $error("outputs off differs from low power");
  a_pin_forces_lp: assert property (i_pd_pin [*5] |-> o_low_power_state)
    else $error("pin did not force low power");
  a_clk_100_en: assert property (o_clk_term_100 |-> o_clk_term_en)
    else $error("clock 100 ohm while unterminated");
  a_data_100_en: assert property (o_data_term_100 |-> o_data_term_en)
    else $error("data 100 ohm while unterminated");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data pull changed while bus clock high");
  a_oe_stands: assert property ($rose(o_sda_oe) |-> o_sda_oe [*6])
    else $error("data pull too short");
  a_powerup_cal: assert property (up_reg >= 16'h0002 &&
    up_reg < CAL_CYCLES - 16'h0002 |-> o_term_cal)
    else $error("no calibration after reset");
  a_cfg_on_write: assert property (up_reg > 16'h0003 &&
    $changed({o_hyst_en, o_hyst_20mv, o_act_mode_cm}) |-> !i_scl)
    else $error("config changed outside a write");
  c_low_power: cover property (o_low_power_state);
  c_data_100: cover property (o_data_term_100);
  c_ack: cover property ($rose(o_sda_oe));
endmodule

bind tmic_regs tmic_regs_assertions #(.CAL_CYCLES(CAL_CYCLES))
  tmic_regs_assertions_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_scl(i_scl), .i_pd_pin(i_pd_pin), .o_sda_oe(o_sda_oe),
  .o_low_power_state(o_low_power_state), .o_outputs_off(o_outputs_off),
  .o_clk_term_en(o_clk_term_en), .o_data_term_en(o_data_term_en),
  .o_clk_term_100(o_clk_term_100), .o_data_term_100(o_data_term_100),
  .o_hyst_en(o_hyst_en), .o_hyst_20mv(o_hyst_20mv),
  .o_act_mode_cm(o_act_mode_cm), .o_term_cal(o_term_cal));

// ===== sim/test_tmic_regs.sv
`timescale 1ns/1ps

module test_tmic_regs;
  import tmic_pkg::*;
  logic       i_clk = 0, i_reset_n = 0, i_pd_pin = 0;
  logic       i_clk_toggle = 0, i_clk_cm_high = 0, tog_en = 0;
  logic       scl, host_low, sda_o, sda_oe;
  logic       lp, off, cte, dte, c100, d100, hy, h20, cm, cal;
  wire        sda_line = (sda_oe ? sda_o : 1'b1) & !host_low;
  wire  [9:0] got = {off, lp, cte, dte, c100, d100, hy, h20, cm, cal};
  int         err_count = 0, tests_run = 0, cyc = 0;
  logic [7:0] corner_v [3] = '{8'h63, 8'h7F, 8'h0F};

  tmic_regs #(.CAL_CYCLES(16'h0010)) tmic_regs_i (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_scl(scl), .i_sda(sda_line), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe), .i_pd_pin(i_pd_pin), .i_clk_toggle(i_clk_toggle),
    .i_clk_cm_high(i_clk_cm_high), .o_low_power_state(lp),
    .o_outputs_off(off), .o_clk_term_en(cte), .o_data_term_en(dte),
    .o_clk_term_100(c100), .o_data_term_100(d100), .o_hyst_en(hy),
    .o_hyst_20mv(h20), .o_act_mode_cm(cm), .o_term_cal(cal));
  tmic_host_model host_i (.i_clk(i_clk), .i_sda(sda_line), .o_scl(scl),
    .o_sda_low(host_low));

  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (tog_en) i_clk_toggle <= ~i_clk_toggle;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      summarize();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [9:0] exp_out(input logic [7:0] v, t,
                                         input logic     p);
    logic ce, de;
    ce = !p && !v[2];
    de = !p && !v[3];
    return {p, p, ce, de, ce && t[6], de && t[2], v[5], v[6], v[4], v[7]};
  endfunction
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] e);
    logic [7:0] d;
    host_i.rd(ofs, d);
    chk({2'b00, d}, {2'b00, e});
  endtask
  task automatic summarize();
    $display("Checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    logic [7:0]  v, t;
    logic [31:0] r;
    r = 32'h030b2fa9;
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (24) @(posedge i_clk);
    chk(got, exp_out(8'h12, 8'h00, 1'b0));
    rd_chk(8'h03, 8'h12);
    rd_chk(8'h04, 8'h00);
    rd_chk(8'h07, 8'h00);
    for (int i = 0; i < 7; i++) begin
      r = xs(r);
      v = (i < 3) ? corner_v[i] : (r[7:0] | 8'h03) & 8'h7F;
      t = (i < 3) ? 8'h44 : r[15:8] & 8'h44;
      host_i.wr(8'h03, v);
      host_i.wr(8'h04, t);
      chk(got, exp_out(v, t, 1'b0));
      rd_chk(8'h03, v);
      rd_chk(8'h04, t);
    end
    host_i.wr(8'h02, 8'h20);
    chk(got, exp_out(v, t, 1'b1));
    rd_chk(8'h02, 8'h20);
    host_i.wr(8'h03, 8'h63);
    rd_chk(8'h03, 8'h63);
    rd_chk(8'h01, 8'h00);
    host_i.wr(8'h02, 8'h00);
    i_pd_pin <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk(got, exp_out(8'h63, t, 1'b1));
    i_pd_pin <= 1'b0;
    repeat (6) @(posedge i_clk);
    chk(got, exp_out(8'h63, t, 1'b0));
    host_i.wr(8'h03, 8'hE3);
    chk(got, exp_out(8'hE3, t, 1'b0));
    host_i.hold_cal();
    host_i.wr(8'h03, 8'h63);
    chk(got, exp_out(8'h63, t, 1'b0));
    tog_en <= 1'b1;
    repeat (10) @(posedge i_clk);
    rd_chk(8'h01, 8'h04);
    tog_en <= 1'b0;
    repeat (100) @(posedge i_clk);
    rd_chk(8'h01, 8'h00);
    host_i.wr(8'h03, 8'h73);
    i_clk_cm_high <= 1'b1;
    repeat (10) @(posedge i_clk);
    rd_chk(8'h01, 8'h04);
    host_i.wr(8'h03, 8'h77);
    rd_chk(8'h01, 8'h00);
    i_clk_cm_high <= 1'b0;
    host_i.dev = 7'h15;
    host_i.wr(8'h03, 8'h00);
    chk({9'h000, host_i.acked}, 10'h000);
    host_i.dev = 7'h2A;
    rd_chk(8'h03, 8'h77);
    summarize();
  end
endmodule
